// *** lbus_pkg.sv ***
// Shared types and constants for the local bus strobe and queue status block.
// Assumes a single 250 MHz clock domain; no software-visible registers.
package lbus_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam real CLK_PERIOD_NS = 4.0;

  // ==========================================================================
  // Byte-lane encodings on {upper_byte_enable_n, address_bit_zero}
  // ==========================================================================
  localparam logic [1:0] LANE_WORD    = 2'h0;
  localparam logic [1:0] LANE_UPPER   = 2'h1;
  localparam logic [1:0] LANE_LOWER   = 2'h2;
  localparam logic [1:0] LANE_REFRESH = 2'h3;

  // ==========================================================================
  // Queue status encodings {hi, lo}
  // ==========================================================================
  localparam logic [1:0] QS_NONE  = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_EMPTY = 2'h2;
  localparam logic [1:0] QS_NEXT  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1   = 3'h1,
    ST_T2   = 3'h2,
    ST_T3   = 3'h3,
    ST_TW   = 3'h4,
    ST_T4   = 3'h5
  } bus_state_t;

  typedef enum logic [1:0] {
    XFER_WORD  = 2'h0,
    XFER_UPPER = 2'h1,
    XFER_LOWER = 2'h2
  } xfer_size_t;

  // Cycle request from the core side.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       refresh;
    xfer_size_t size;
  } cycle_req_t;

  // Queue event from the instruction side.
  typedef struct packed {
    logic first_byte;
    logic next_byte;
    logic flush;
  } queue_evt_t;

endpackage : lbus_pkg

// *** ready_sync.sv ***
// Ready input conditioning for the local bus.
// Assumes async_ready may rise at any time and falls in step with the clock.
`timescale 1ns/1ps
module ready_sync
  import lbus_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic async_ready,
  input  wire logic sync_ready,
  output logic      ready
);

  logic async_meta_reg;
  logic async_sync_reg;
  logic sync_reg;
  logic ready_next;

  always_comb begin
    ready_next = async_sync_reg | sync_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      async_meta_reg <= 1'b0;
      async_sync_reg <= 1'b0;
      sync_reg       <= 1'b0;
    end else begin
      async_meta_reg <= async_ready;
      async_sync_reg <= async_meta_reg;
      sync_reg       <= sync_ready;
    end
  end

  // Combined ready: either input ends the wait, a held-high input never waits.
  assign ready = ready_next;

endmodule : ready_sync

// *** lbus_ctrl.sv ***
// Local bus strobe, byte lane, refresh and queue status generation.
// Assumes the core issues one cycle request at a time and pins are sampled here.
`timescale 1ns/1ps
module lbus_ctrl
  import lbus_pkg::*;
#(
  parameter bit BYTE_BUS = 1'b0
)(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire cycle_req_t cycle_req,
  input  wire queue_evt_t queue_evt,
  input  wire logic       enhanced_mode,
  input  wire logic       read_strobe_in,
  input  wire logic       async_ready,
  input  wire logic       sync_ready,
  output logic            cycle_done,
  output logic            upper_byte_enable_n,
  output logic            address_bit_zero,
  output logic            ad_bus_oe,
  output logic            ale_qs_lo,
  output logic            wr_qs_hi,
  output logic            read_strobe_n,
  output logic            read_strobe_oe,
  output logic            queue_mode
);

  // ==========================================================================
  // Reset release and pin synchronisers
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_n;
  logic rd_meta_reg;
  logic rd_sync_reg;
  logic ready;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_meta_reg <= 1'b1;
      rd_sync_reg <= 1'b1;
    end else begin
      rd_meta_reg <= read_strobe_in;
      rd_sync_reg <= rd_meta_reg;
    end
  end

  ready_sync u_ready (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .async_ready (async_ready),
    .sync_ready  (sync_ready),
    .ready       (ready)
  );

  // ==========================================================================
  // Mode strap
  // ==========================================================================
  // The strap is caught once, after the synchroniser has settled on the pin.
  logic strap_done_reg;
  logic strap_done_next;
  logic queue_mode_reg;
  logic queue_mode_next;
  logic [1:0] strap_cnt_reg;
  logic [1:0] strap_cnt_next;

  always_comb begin
    strap_done_next = strap_done_reg;
    queue_mode_next = queue_mode_reg;
    strap_cnt_next  = strap_cnt_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == 2'h2) begin
        strap_done_next = 1'b1;
        queue_mode_next = ~rd_sync_reg;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      queue_mode_reg <= 1'b0;
      strap_cnt_reg  <= 2'h0;
    end else begin
      strap_done_reg <= strap_done_next;
      queue_mode_reg <= queue_mode_next;
      strap_cnt_reg  <= strap_cnt_next;
    end
  end

  // ==========================================================================
  // Bus cycle sequencer
  // ==========================================================================
  function automatic logic [1:0] lane_code(input cycle_req_t r, input logic enh);
    if (r.refresh && enh) begin
      lane_code = LANE_REFRESH;
    end else begin
      unique case (r.size)
        XFER_WORD:  lane_code = LANE_WORD;
        XFER_UPPER: lane_code = LANE_UPPER;
        default:    lane_code = LANE_LOWER;
      endcase
    end
  endfunction : lane_code

  bus_state_t state_reg;
  bus_state_t state_next;
  cycle_req_t cur_reg;
  cycle_req_t cur_next;
  logic       ube_n_reg, ube_n_next;
  logic       a0_reg, a0_next;
  logic       ad_oe_reg, ad_oe_next;
  logic       ale_reg, ale_next;
  logic       wr_n_reg, wr_n_next;
  logic       rd_n_reg, rd_n_next;
  logic       done_reg, done_next;
  logic [1:0] qs_next;
  logic [1:0] lane;

  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    ale_next   = 1'b0;
    wr_n_next  = 1'b1;
    rd_n_next  = 1'b1;
    ad_oe_next = 1'b0;
    done_next  = 1'b0;
    ube_n_next = ube_n_reg;
    a0_next    = a0_reg;
    lane       = lane_code(cur_reg, enhanced_mode);
    unique case (state_reg)
      ST_IDLE: begin
        ube_n_next = 1'b1;
        if (cycle_req.valid && strap_done_reg) begin
          cur_next   = cycle_req;
          state_next = ST_T1;
          ale_next   = 1'b1;
          ad_oe_next = 1'b1;
          lane       = lane_code(cycle_req, enhanced_mode);
          if (BYTE_BUS) begin
            ube_n_next = ~cycle_req.refresh;
          end else begin
            ube_n_next = lane[1];
          end
          a0_next = lane[0];
        end
      end
      ST_T1: begin
        // Address leaves the bus here; read strobe falls one state later.
        state_next = ST_T2;
        ad_oe_next = cur_reg.write;
        wr_n_next  = ~cur_reg.write;
      end
      ST_T2, ST_T3, ST_TW: begin
        ad_oe_next = cur_reg.write;
        wr_n_next  = ~cur_reg.write;
        rd_n_next  = cur_reg.write | cur_reg.refresh;
        if (state_reg == ST_T2) begin
          state_next = ST_T3;
        end else if (ready) begin
          state_next = ST_T4;
          wr_n_next  = 1'b1;
          rd_n_next  = 1'b1;
          done_next  = 1'b1;
        end else begin
          state_next = ST_TW;
        end
      end
      ST_T4: begin
        state_next = ST_IDLE;
        ube_n_next = 1'b1;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Queue status: next byte wins over first byte, flush wins over both.
  always_comb begin
    qs_next = QS_NONE;
    if (queue_evt.flush) begin
      qs_next = QS_EMPTY;
    end else if (queue_evt.next_byte) begin
      qs_next = QS_NEXT;
    end else if (queue_evt.first_byte) begin
      qs_next = QS_FIRST;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
      ube_n_reg <= 1'b1;
      a0_reg    <= 1'b0;
      ad_oe_reg <= 1'b0;
      ale_reg   <= 1'b0;
      wr_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      ube_n_reg <= ube_n_next;
      a0_reg    <= a0_next;
      ad_oe_reg <= ad_oe_next;
      ale_reg   <= ale_next;
      wr_n_reg  <= wr_n_next;
      rd_n_reg  <= rd_n_next;
      done_reg  <= done_next;
    end
  end

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  logic ale_out_reg;
  logic wr_out_reg, rd_oe_out_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_out_reg <= 1'b0;
      wr_out_reg  <= 1'b1;
      rd_oe_out_reg <= 1'b0;
    end else begin
      ale_out_reg <= queue_mode_next ? qs_next[0] : ale_next;
      wr_out_reg  <= queue_mode_next ? qs_next[1] : wr_n_next;
      rd_oe_out_reg <= strap_done_next & ~queue_mode_next;
    end
  end

  assign ale_qs_lo           = ale_out_reg;
  assign wr_qs_hi            = wr_out_reg;
  assign upper_byte_enable_n = ube_n_reg;
  assign address_bit_zero    = a0_reg;
  assign ad_bus_oe           = ad_oe_reg;
  assign read_strobe_n       = rd_n_reg;
  assign read_strobe_oe      = rd_oe_out_reg;
  assign queue_mode          = queue_mode_reg;
  assign cycle_done          = done_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_addr_phase;
    state_reg == ST_T1;
  endsequence

  AST_ALE_IN_T1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_addr_phase |-> ale_reg && (ad_oe_reg == 1'b1)) else $error("ALE not high in T1");
  AST_ALE_FALLS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_addr_phase |=> !ale_reg) else $error("ALE did not fall after T1");
  AST_RD_AFTER_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(rd_n_reg) |-> !ad_oe_reg && $past(!ad_oe_reg)) else $error("RD fell with bus driven");
  AST_WR_ONLY_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_n_reg |-> cur_reg.write) else $error("WR low in non-write cycle");
  AST_REFRESH_LANES: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_addr_phase and (cur_reg.refresh && enhanced_mode && !BYTE_BUS))
    |-> ube_n_reg && a0_reg) else $error("Refresh lane code wrong");
  AST_UBE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_addr_phase and !ube_n_reg) |=> !ube_n_reg [*2]) else $error("UBE released early");
  AST_WAIT_NO_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_T3 && !ready) |=> state_reg == ST_TW) else $error("No wait state");
  AST_DONE_ON_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_TW && ready) |=> done_reg && state_reg == ST_T4) else $error("Ready ignored");
  AST_QS_FLUSH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (queue_evt.flush && queue_mode_reg) |=> {wr_out_reg, ale_out_reg} == QS_EMPTY)
    else $error("Flush code wrong");

endmodule : lbus_ctrl

// *** far_bus_model.sv ***
// Behavioural far side: addressed memory or I/O device, board strap and ready sources.
// Assumes the strobe pins of lbus_ctrl and the free-running sys_clk.
`timescale 1ns/1ps
module far_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       strap_gnd,
  input  wire logic [1:0] rdy_mode,
  input  wire logic [3:0] rdy_delay,
  input  wire logic       queue_mode,
  input  wire logic       wr_qs_hi,
  input  wire logic       read_strobe_n,
  input  wire logic       read_strobe_oe,
  output logic            read_pin,
  output logic            async_ready,
  output logic            sync_ready
);
  logic       strobe;
  logic [3:0] cnt;
  // A floating pin rests on the pull-up unless the board grounds it.
  assign read_pin = read_strobe_oe ? read_strobe_n : !strap_gnd;
  assign strobe   = !read_strobe_n || (!queue_mode && !wr_qs_hi);
  initial begin
    async_ready = 1'b0;
    sync_ready  = 1'b0;
    cnt         = 4'h0;
  end
  // Mode 0 slow async, mode 1 slow sync with async tied low, mode 2 async tied high.
  always @(posedge sys_clk) begin
    if (!strobe) begin
      cnt <= 4'h0;
      async_ready <= (rdy_mode == 2'h2);
      sync_ready  <= 1'b0;
    end else if (cnt < rdy_delay) begin
      cnt <= cnt + 4'h1;
    end else if (rdy_mode == 2'h1) begin
      sync_ready <= #1 1'b1;
    end else if (rdy_mode == 2'h0) begin
      async_ready <= #1.3 1'b1;
    end
  end
endmodule : far_bus_model

// *** tb_lbus_ctrl.sv ***
// Self-checking testbench for lbus_ctrl, a 16-bit and an 8-bit instance side by side.
// Assumes far_bus_model plays the device, strap and ready sources.
`timescale 1ns/1ps
module tb_lbus_ctrl;
  import lbus_pkg::*;
  logic       sys_clk, nrst, enhanced_mode, strap_gnd, read_pin, async_ready, sync_ready;
  logic       cycle_done, upper_byte_enable_n, address_bit_zero, ad_bus_oe, ale_qs_lo;
  logic       wr_qs_hi, read_strobe_n, read_strobe_oe, queue_mode, byte_ube_n;
  logic [1:0] rdy_mode;
  logic [3:0] rdy_delay;
  cycle_req_t cycle_req;
  queue_evt_t queue_evt;
  int         errors, num_checks;
  // ==========================================================================
  // Instances
  // ==========================================================================
  lbus_ctrl lbus_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .cycle_req(cycle_req),
    .queue_evt(queue_evt), .enhanced_mode(enhanced_mode), .read_strobe_in(read_pin),
    .async_ready(async_ready), .sync_ready(sync_ready), .cycle_done(cycle_done),
    .upper_byte_enable_n(upper_byte_enable_n), .address_bit_zero(address_bit_zero),
    .ad_bus_oe(ad_bus_oe), .ale_qs_lo(ale_qs_lo), .wr_qs_hi(wr_qs_hi),
    .read_strobe_n(read_strobe_n), .read_strobe_oe(read_strobe_oe), .queue_mode(queue_mode));
  lbus_ctrl #(.BYTE_BUS(1'b1)) lbus_ctrl_byte_inst (.sys_clk(sys_clk), .nrst(nrst),
    .cycle_req(cycle_req), .queue_evt(queue_evt), .enhanced_mode(enhanced_mode),
    .read_strobe_in(read_pin), .async_ready(async_ready), .sync_ready(sync_ready),
    .cycle_done(), .upper_byte_enable_n(byte_ube_n), .address_bit_zero(), .ad_bus_oe(),
    .ale_qs_lo(), .wr_qs_hi(), .read_strobe_n(), .read_strobe_oe(), .queue_mode());
  far_bus_model far_bus_model_inst (.sys_clk(sys_clk), .strap_gnd(strap_gnd),
    .rdy_mode(rdy_mode), .rdy_delay(rdy_delay), .queue_mode(queue_mode),
    .wr_qs_hi(wr_qs_hi), .read_strobe_n(read_strobe_n), .read_strobe_oe(read_strobe_oe),
    .read_pin(read_pin), .async_ready(async_ready), .sync_ready(sync_ready));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(input logic strap);
    strap_gnd = strap;
    nrst = 1'b0;
    repeat (16) @(posedge sys_clk);
    check(read_pin, !strap);
    check({wr_qs_hi, ale_qs_lo}, 2'h2);
    #1 nrst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    check(queue_mode, strap);
    check(read_strobe_oe, !strap);
  endtask : do_reset
  // Runs one bus cycle; the far side's ready mode decides how long it lasts.
  task automatic run_cycle(input logic wr, input logic rf, input xfer_size_t sz,
                           input logic [1:0] lane);
    int   n;
    logic seen_rdy, seen_rd, seen_wr;
    seen_rdy = 1'b0;
    seen_rd  = 1'b0;
    seen_wr  = 1'b0;
    cycle_req = '{1'b1, wr, rf, sz};
    @(posedge sys_clk);
    #1 cycle_req.valid = 1'b0;
    check({upper_byte_enable_n, address_bit_zero}, lane);
    check(byte_ube_n, !rf);
    if (!queue_mode) check(ale_qs_lo, 1'b1);
    check(ad_bus_oe, 1'b1);
    for (n = 0; n < 40 && cycle_done !== 1'b1; n++) begin
      seen_rdy |= async_ready | sync_ready;
      @(posedge sys_clk);
      #1;
      check({upper_byte_enable_n, address_bit_zero}, lane);
      if (queue_mode) check({wr_qs_hi, ale_qs_lo}, QS_NONE);
      else if (n == 0) check(ale_qs_lo, 1'b0);
      if (!read_strobe_n) check(ad_bus_oe, 1'b0);
      seen_rd |= !read_strobe_n;
      seen_wr |= !queue_mode && !wr_qs_hi;
    end
    check(cycle_done, 1'b1);
    if (cycle_done !== 1'b1) report_and_stop();
    check(seen_rdy, 1'b1);
    if (rdy_mode != 2'h2) check(n > rdy_delay, 1'b1);
    else check(n == 3, 1'b1);
    if (!rf) check(seen_rd, !wr);
    if (!rf && !queue_mode) check(seen_wr, wr);
    @(posedge sys_clk);
    #1 check(read_strobe_n, 1'b1);
    if (!queue_mode) check(wr_qs_hi, 1'b1);
  endtask : run_cycle
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_lanes;
    rdy_mode = 2'h2;
    run_cycle(1'b0, 1'b0, XFER_WORD, LANE_WORD);
    run_cycle(1'b1, 1'b0, XFER_UPPER, LANE_UPPER);
    run_cycle(1'b0, 1'b0, XFER_LOWER, LANE_LOWER);
    run_cycle(1'b0, 1'b1, XFER_WORD, LANE_REFRESH);
    // Outside enhanced mode a refresh keeps the plain byte lane code.
    enhanced_mode = 1'b0;
    run_cycle(1'b0, 1'b1, XFER_LOWER, LANE_LOWER);
    enhanced_mode = 1'b1;
    $display("test lanes finished");
  endtask : test_lanes
  // Back-to-back write and read with long waits, async then sync ready.
  task automatic test_waits;
    rdy_delay = 4'h9;
    for (int m = 0; m < 2; m++) begin
      rdy_mode = m[1:0];
      run_cycle(1'b1, 1'b0, XFER_WORD, LANE_WORD);
      run_cycle(1'b0, 1'b0, XFER_UPPER, LANE_UPPER);
    end
    rdy_delay = 4'h0;
    rdy_mode = 2'h2;
    $display("test waits finished");
  endtask : test_waits
  task automatic test_queue;
    queue_evt_t ev [5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h7};
    logic [1:0] qs [5] = '{QS_NONE, QS_FIRST, QS_NEXT, QS_EMPTY, QS_EMPTY};
    do_reset(1'b1);
    for (int i = 0; i < 5; i++) begin
      queue_evt = ev[i];
      @(posedge sys_clk);
      #1 queue_evt = '0;
      check({wr_qs_hi, ale_qs_lo}, qs[i]);
    end
    run_cycle(1'b1, 1'b0, XFER_WORD, LANE_WORD);
    $display("test queue finished");
  endtask : test_queue
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    cycle_req = '0;
    queue_evt = '0;
    enhanced_mode = 1'b1;
    strap_gnd = 1'b0;
    rdy_mode = 2'h2;
    rdy_delay = 4'h0;
    @(posedge sys_clk);
    #1 do_reset(1'b0);
    test_lanes();
    test_waits();
    test_queue();
    report_and_stop();
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule : tb_lbus_ctrl
